/* src/ers_map.svh */
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH

// Page codes that are passed through to the enclosure.
`define ERS_PAGE_FIRST 8'h01
`define ERS_PAGE_LAST 8'h0f
// Short status page for legacy parallel-capable enclosures.
`define ERS_SHORT_PAGE_CODE 8'h08
`define ERS_SHORT_LEGACY_BIT 7
`define ERS_SHORT_HIGH_BIT 1
`define ERS_SHORT_LOW_BIT 0
`define ERS_SHORT_PAGE_LEN 16'h0000
`define ERS_SHORT_BYTES 16'h0004
// Command phase layout.
`define ERS_CMD_BYTES 2'h3
`define ERS_CMD_SEND_BIT 0
`define ERS_CMD_PARAM_LEN 16'h0000
// Header size added to the page length.
`define ERS_HDR_BYTES 17'h00004
// Sense codes.
`define ERS_ASC_ENCL 8'h35
`define ERS_ASCQ_UNSUPPORTED 8'h01
`define ERS_ASCQ_UNAVAILABLE 8'h02
`define ERS_ASCQ_REFUSED 8'h03
`define ERS_ASCQ_FAILED 8'h04
// Clock rate and least timeouts, in their own units.
`define ERS_CLK_HZ 50000000
`define ERS_DISC_TIMEOUT_MS 1000
`define ERS_FIRST_RD_TIMEOUT_MS 1
`define ERS_BYTE_TIMEOUT_US 100

`endif

/* src/ers_pkg.sv */
package ers_pkg;

  // Sequencer states.
  typedef enum logic [3:0] {
    ERS_IDLE,
    ERS_DISC,
    ERS_DISC_ACK,
    ERS_DISC_REL,
    ERS_CMD_STB,
    ERS_CMD_REL,
    ERS_RD_STB,
    ERS_RD_REL,
    ERS_SHORT
  } ers_state_e;

endpackage : ers_pkg

/* src/ers_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Restartable timeout counter.
// ****************************************************************
module ers_timer #(
  parameter int unsigned W = 26
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Control.
  input wire logic restart,
  input wire logic [W-1:0] limit,
  // Status.
  output logic expired
);

  // Cycles elapsed since the last restart.
  logic [W-1:0] count_reg;
  // Expiry flag.
  logic expired_reg;
  // Last count before expiry.
  wire logic at_limit = (count_reg == (limit - W'(1)));

  assign expired = expired_reg;

  // Counting stops once the limit has passed; a restart always wins.
  always_ff @(posedge sys_clk) begin
    if (srst || restart) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else if (!expired_reg) begin
      count_reg <= count_reg + W'(1);
      expired_reg <= at_limit;
    end
  end

endmodule // ers_timer

`default_nettype wire

/* src/ers_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ers_map.svh"


// ****************************************************************
// Receive-diagnostic sequencer toward the enclosure link.
// ****************************************************************
module ers_sequencer #(
  parameter int unsigned DISC_TIMEOUT_CYC = `ERS_DISC_TIMEOUT_MS * (`ERS_CLK_HZ / 1000),
  parameter int unsigned FIRST_RD_TIMEOUT_CYC = `ERS_FIRST_RD_TIMEOUT_MS * (`ERS_CLK_HZ / 1000),
  parameter int unsigned BYTE_TIMEOUT_CYC = `ERS_BYTE_TIMEOUT_US * (`ERS_CLK_HZ / 1000000)
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Host request.
  input wire logic host_req,
  input wire logic [7:0] host_page_code,
  input wire logic [15:0] host_alloc_len,
  // Host answer and data stream.
  output logic host_busy,
  output logic host_done,
  output logic host_check,
  output logic [7:0] host_asc,
  output logic [7:0] host_ascq,
  output logic host_data_valid,
  output logic [7:0] host_data,
  // Discovery logic on the same clock.
  output logic disc_start,
  input wire logic disc_done,
  input wire logic disc_compliant,
  input wire logic disc_legacy_link_ok,
  // Enclosure link pins.
  output logic enclosure_link_request_n,
  output logic device_write_strobe_n,
  output logic device_read_strobe_n,
  input wire logic enclosure_acknowledge_n,
  input wire logic legacy_link_bit_high,
  input wire logic legacy_link_bit_low,
  input wire logic [7:0] link_data_in,
  output logic [7:0] link_data_out,
  output logic link_data_oe
);

  localparam int unsigned TW = 26;
  localparam int unsigned NS = 11;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************

  // Raw pins: data, two legacy bits, acknowledge.
  wire logic [NS-1:0] pin_raw = {link_data_in, legacy_link_bit_high, legacy_link_bit_low,
                                 enclosure_acknowledge_n};
  // Three stages and the accepted level.
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  logic [NS-1:0] lvl_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      // A change counts once the second and third stages agree.
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          lvl_reg[gi] <= 1'b1;
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            lvl_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // Acknowledge is active low on the pin.
  wire logic ack = ~lvl_reg[0];
  wire logic [1:0] legacy_bits = lvl_reg[2:1];
  wire logic [7:0] rd_byte = lvl_reg[10:3];

  // ****************************************************************
  // State registers.
  // ****************************************************************

  ers_pkg::ers_state_e state_reg, state_next;
  logic [7:0] page_reg, page_next;         // Requested page code.
  logic [15:0] alloc_reg, alloc_next;      // Host allocation length.
  logic [16:0] limit_reg, limit_next;      // Bytes to move.
  logic [15:0] cnt_reg, cnt_next;          // Bytes moved so far.
  logic [1:0] cmd_idx_reg, cmd_idx_next;   // Command byte index.
  logic [7:0] len_hi_reg, len_hi_next;     // Page length high byte.
  logic first_reg, first_next;             // First read strobe pending.
  logic req_n_reg, req_n_next;
  logic wr_n_reg, wr_n_next;
  logic rd_n_reg, rd_n_next;
  logic oe_reg, oe_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic check_reg, check_next;
  logic [7:0] asc_reg, asc_next;
  logic [7:0] ascq_reg, ascq_next;
  logic dv_reg, dv_next;
  logic [7:0] dout_reg, dout_next;
  logic dstart_reg, dstart_next;
  logic restart_next;                      // Timer restart request.

  // ****************************************************************
  // Decoding and selection.
  // ****************************************************************

  // Page codes that go to the enclosure.
  // Range check.
  wire logic page_in_range = (host_page_code >= `ERS_PAGE_FIRST) &&
                             (host_page_code <= `ERS_PAGE_LAST);
  // Next command byte: page code, send bit and length all zero.
  // Command contents.
  wire logic [7:0] cmd_byte = (cmd_idx_next == 2'h0) ? page_reg :
                              (cmd_idx_next == 2'h1) ? 8'h00 :
                              (cmd_idx_next == 2'h2) ? 8'(`ERS_CMD_PARAM_LEN >> 8) :
                              8'(`ERS_CMD_PARAM_LEN & 16'h00ff);
  // Short status page bytes.
  // Short page layout.
  wire logic [7:0] short_b1 = (8'h01 << `ERS_SHORT_LEGACY_BIT) |
                              ({7'h00, legacy_bits[1]} << `ERS_SHORT_HIGH_BIT) |
                              ({7'h00, legacy_bits[0]} << `ERS_SHORT_LOW_BIT);
  wire logic [7:0] short_byte = (cnt_reg == 16'h0000) ? `ERS_SHORT_PAGE_CODE :
                                (cnt_reg == 16'h0001) ? short_b1 :
                                (cnt_reg == 16'h0002) ? 8'(`ERS_SHORT_PAGE_LEN >> 8) :
                                8'(`ERS_SHORT_PAGE_LEN & 16'h00ff);
  // Total length from header bytes 2 and 3, capped by the allocation.
  // Smaller of the two.
  wire logic [16:0] page_total = {1'b0, len_hi_reg, rd_byte} + `ERS_HDR_BYTES;
  wire logic [16:0] alloc_w = {1'b0, alloc_reg};
  wire logic [16:0] capped = (page_total < alloc_w) ? page_total : alloc_w;
  wire logic [15:0] short_total = (alloc_reg < `ERS_SHORT_BYTES) ? alloc_reg : `ERS_SHORT_BYTES;
  // Timeout limit by phase.
  // Counters sized to least times.
  wire logic [TW-1:0] timer_limit = (state_reg == ers_pkg::ERS_DISC_ACK) ? TW'(DISC_TIMEOUT_CYC) :
                                    first_reg ? TW'(FIRST_RD_TIMEOUT_CYC) :
                                    TW'(BYTE_TIMEOUT_CYC);
  wire logic timed_out;

  // Restarted from next-state logic: no stale expiry.
  ers_timer #(.W(TW)) u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .restart(restart_next),
    .limit(timer_limit),
    .expired(timed_out)
  );

  // ****************************************************************
  // Sequencer next-state logic.
  // ****************************************************************

  always_comb begin
    logic fin;
    logic fin_chk;
    logic [7:0] fin_ascq;
    fin = 1'b0;
    fin_chk = 1'b0;
    fin_ascq = 8'h00;
    state_next = state_reg;
    page_next = page_reg;
    alloc_next = alloc_reg;
    limit_next = limit_reg;
    cnt_next = cnt_reg;
    cmd_idx_next = cmd_idx_reg;
    len_hi_next = len_hi_reg;
    first_next = first_reg;
    req_n_next = req_n_reg;
    wr_n_next = wr_n_reg;
    rd_n_next = rd_n_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    check_next = check_reg;
    asc_next = asc_reg;
    ascq_next = ascq_reg;
    dv_next = 1'b0;
    dout_next = dout_reg;
    dstart_next = 1'b0;
    restart_next = 1'b0;
    case (state_reg)
      // Wait for a request; out-of-range pages are left to other logic.
      ers_pkg::ERS_IDLE: begin
        if (host_req && page_in_range) begin
          page_next = host_page_code;
          alloc_next = host_alloc_len;
          busy_next = 1'b1;
          req_n_next = 1'b0;
          dstart_next = 1'b1;
          state_next = ers_pkg::ERS_DISC;
        end
      end
      // Discovery result from the discovery logic.
      ers_pkg::ERS_DISC: begin
        if (disc_done) begin
          if (disc_compliant) begin
            restart_next = 1'b1;
            state_next = ers_pkg::ERS_DISC_ACK;
          end else if (disc_legacy_link_ok) begin
            req_n_next = 1'b1;
            cnt_next = 16'h0000;
            state_next = ers_pkg::ERS_SHORT;
          end else begin
            fin = 1'b1;
            fin_chk = 1'b1;
            fin_ascq = `ERS_ASCQ_UNSUPPORTED;
          end
        end
      end
      // Compliant enclosure must acknowledge within the long timeout.
      ers_pkg::ERS_DISC_ACK: begin
        if (ack) begin
          restart_next = 1'b1;
          state_next = ers_pkg::ERS_DISC_REL;
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = `ERS_ASCQ_UNAVAILABLE;
        end
      end
      // Acknowledge released: the enclosure is responding correctly.
      ers_pkg::ERS_DISC_REL: begin
        if (!ack) begin
          cmd_idx_next = 2'h0;
          wr_n_next = 1'b0;
          oe_next = 1'b1;
          restart_next = 1'b1;
          state_next = ers_pkg::ERS_CMD_STB;
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = `ERS_ASCQ_REFUSED;
        end
      end
      // Write strobe low, waiting for acknowledge.
      ers_pkg::ERS_CMD_STB: begin
        if (ack) begin
          wr_n_next = 1'b1;
          restart_next = 1'b1;
          state_next = ers_pkg::ERS_CMD_REL;
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = `ERS_ASCQ_REFUSED;
        end
      end
      // Strobe high, waiting for acknowledge release.
      ers_pkg::ERS_CMD_REL: begin
        if (!ack) begin
          restart_next = 1'b1;
          if (cmd_idx_reg == `ERS_CMD_BYTES) begin
            oe_next = 1'b0;
            cnt_next = 16'h0000;
            limit_next = alloc_w;
            first_next = 1'b1;
            if (alloc_reg == 16'h0000) begin
              fin = 1'b1;
            end else begin
              rd_n_next = 1'b0;
              state_next = ers_pkg::ERS_RD_STB;
            end
          end else begin
            cmd_idx_next = cmd_idx_reg + 2'h1;
            wr_n_next = 1'b0;
            state_next = ers_pkg::ERS_CMD_STB;
          end
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = `ERS_ASCQ_REFUSED;
        end
      end
      // Read strobe low, waiting for acknowledge with data.
      ers_pkg::ERS_RD_STB: begin
        if (ack) begin
          dv_next = 1'b1;
          dout_next = rd_byte;
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == 16'h0002) begin
            len_hi_next = rd_byte;
          end
          if (cnt_reg == 16'h0003) begin
            limit_next = capped;
          end
          first_next = 1'b0;
          rd_n_next = 1'b1;
          restart_next = 1'b1;
          state_next = ers_pkg::ERS_RD_REL;
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = first_reg ? `ERS_ASCQ_REFUSED : `ERS_ASCQ_FAILED;
        end
      end
      // Strobe high, waiting for acknowledge release.
      ers_pkg::ERS_RD_REL: begin
        if (!ack) begin
          if ({1'b0, cnt_reg} >= limit_reg) begin
            fin = 1'b1;
          end else begin
            rd_n_next = 1'b0;
            restart_next = 1'b1;
            state_next = ers_pkg::ERS_RD_STB;
          end
        end else if (timed_out) begin
          fin = 1'b1;
          fin_chk = 1'b1;
          fin_ascq = `ERS_ASCQ_FAILED;
        end
      end
      // Short page bytes, one per cycle, capped by the allocation.
      ers_pkg::ERS_SHORT: begin
        if (cnt_reg >= short_total) begin
          fin = 1'b1;
        end else begin
          dv_next = 1'b1;
          dout_next = short_byte;
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = ers_pkg::ERS_IDLE;
      end
    endcase
    // Every ending releases the link and reports once.
    if (fin) begin
      state_next = ers_pkg::ERS_IDLE;
      req_n_next = 1'b1;
      wr_n_next = 1'b1;
      rd_n_next = 1'b1;
      oe_next = 1'b0;
      busy_next = 1'b0;
      done_next = 1'b1;
      first_next = 1'b0;
      check_next = fin_chk;
      asc_next = fin_chk ? `ERS_ASC_ENCL : 8'h00;
      ascq_next = fin_ascq;
    end
  end

  // ****************************************************************
  // State update.
  // ****************************************************************

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ers_pkg::ERS_IDLE;
      {page_reg, alloc_reg, limit_reg, cnt_reg, cmd_idx_reg, len_hi_reg} <= '0;
      {first_reg, oe_reg, busy_reg, done_reg, check_reg, dv_reg, dstart_reg} <= '0;
      {asc_reg, ascq_reg, dout_reg} <= '0;
      {req_n_reg, wr_n_reg, rd_n_reg} <= 3'h7;
    end else begin
      state_reg <= state_next;
      {page_reg, alloc_reg, limit_reg, cnt_reg} <= {page_next, alloc_next, limit_next, cnt_next};
      {cmd_idx_reg, len_hi_reg, first_reg} <= {cmd_idx_next, len_hi_next, first_next};
      {req_n_reg, wr_n_reg, rd_n_reg, oe_reg} <= {req_n_next, wr_n_next, rd_n_next, oe_next};
      {busy_reg, done_reg, check_reg, dv_reg} <= {busy_next, done_next, check_next, dv_next};
      {asc_reg, ascq_reg, dout_reg} <= {asc_next, ascq_next, dout_next};
      dstart_reg <= dstart_next;
    end
  end

  // Outputs straight from flip-flops; command data is registered below.
  logic [7:0] lout_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lout_reg <= 8'h00;
    end else begin
      lout_reg <= cmd_byte;
    end
  end

  assign host_busy = busy_reg;
  assign host_done = done_reg;
  assign host_check = check_reg;
  assign host_asc = asc_reg;
  assign host_ascq = ascq_reg;
  assign host_data_valid = dv_reg;
  assign host_data = dout_reg;
  assign disc_start = dstart_reg;
  assign enclosure_link_request_n = req_n_reg;
  assign device_write_strobe_n = wr_n_reg;
  assign device_read_strobe_n = rd_n_reg;
  assign link_data_out = lout_reg;
  assign link_data_oe = oe_reg;

endmodule // ers_sequencer

`default_nettype wire

/* testbench/ers_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker for the read sequencer.
// ****************************************
module ers_properties #(
  parameter int unsigned DISC_TIMEOUT_CYC = 200,
  parameter int unsigned FIRST_RD_TIMEOUT_CYC = 50,
  parameter int unsigned BYTE_TIMEOUT_CYC = 20
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Host side.
  input wire logic host_req,
  input wire logic [7:0] host_page_code,
  input wire logic host_busy,
  input wire logic host_done,
  input wire logic host_check,
  input wire logic [7:0] host_asc,
  input wire logic [7:0] host_ascq,
  input wire logic disc_start,
  // Link side.
  input wire logic enclosure_link_request_n,
  input wire logic device_write_strobe_n,
  input wire logic device_read_strobe_n,
  input wire logic link_data_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Cycles for which each strobe has been held low.
  int wr_cnt;
  int rd_cnt;
  always_ff @(posedge sys_clk) begin
    wr_cnt <= device_write_strobe_n ? 0 : wr_cnt + 1;
    rd_cnt <= device_read_strobe_n ? 0 : rd_cnt + 1;
  end
  a_start_valid_code: assert property (
    $rose(host_busy) |-> $past(host_req) && ($past(host_page_code) inside {[8'h01:8'h0f]}))
    else $error("busy without a valid request");
  a_disc_start_link: assert property (
    disc_start |-> host_busy && !enclosure_link_request_n ##1 !disc_start)
    else $error("discovery start out of place");
  a_done_ends_busy: assert property (
    host_done |-> !host_busy && $past(host_busy))
    else $error("done and busy disagree");
  a_done_link_free: assert property (
    host_done |-> enclosure_link_request_n && device_write_strobe_n && device_read_strobe_n)
    else $error("link still held at done");
  a_good_no_sense: assert property (
    host_done && !host_check |-> host_asc == 8'h00 && host_ascq == 8'h00)
    else $error("sense set on good status");
  a_check_sense: assert property (
    host_done && host_check |-> host_asc == 8'h35 && (host_ascq inside {[8'h01:8'h04]}))
    else $error("bad sense on check");
  a_write_drives_bus: assert property (
    !device_write_strobe_n |-> link_data_oe && !enclosure_link_request_n)
    else $error("write strobe without driven data");
  a_write_wait_bound: assert property (
    wr_cnt <= BYTE_TIMEOUT_CYC + 6)
    else $error("write strobe held too long");
  a_read_wait_bound: assert property (
    rd_cnt <= FIRST_RD_TIMEOUT_CYC + 6)
    else $error("read strobe held too long");
endmodule // ers_properties

bind ers_sequencer ers_properties #(
  .DISC_TIMEOUT_CYC(DISC_TIMEOUT_CYC), .FIRST_RD_TIMEOUT_CYC(FIRST_RD_TIMEOUT_CYC),
  .BYTE_TIMEOUT_CYC(BYTE_TIMEOUT_CYC)
) i_ers_properties (
  .sys_clk, .srst, .host_req, .host_page_code, .host_busy, .host_done, .host_check,
  .host_asc, .host_ascq, .disc_start, .enclosure_link_request_n, .device_write_strobe_n,
  .device_read_strobe_n, .link_data_oe
);

`default_nettype wire

/* testbench/ers_encl_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Enclosure processor on the strobe link.
// ****************************************
module ers_encl_model (
  // Clock.
  input wire logic sys_clk,
  // Pins from the device.
  input wire logic enclosure_link_request_n,
  input wire logic device_write_strobe_n,
  input wire logic device_read_strobe_n,
  input wire logic [7:0] link_data_out,
  // Pins toward the device.
  output logic enclosure_acknowledge_n,
  output logic [7:0] link_data_in,
  // Behaviour chosen by the bench.
  input wire logic [3:0] dly,
  input wire logic mute_disc,
  input wire logic [7:0] stall_wr,
  input wire logic [7:0] stall_rd,
  input wire logic [15:0] page_len,
  // Command bytes seen, byte 0 lowest.
  output logic [31:0] cmd_seen
);
  int cnt = 0;
  int nrd = 0;
  int ncmd = 0;
  logic disc_pend = 1'b1;
  wire strobe = !device_write_strobe_n || !device_read_strobe_n;
  wire stall = (!device_write_strobe_n && ncmd == int'(stall_wr)) ||
    (!device_read_strobe_n && nrd == int'(stall_rd));
  initial begin
    enclosure_acknowledge_n = 1'b1;
    link_data_in = 8'h3c;
    cmd_seen = 32'h00000000;
  end
  function automatic logic [7:0] pbyte(input int i);
    case (i)
      0: return cmd_seen[7:0];
      1: return 8'h5a;
      2: return page_len[15:8];
      3: return page_len[7:0];
      default: return 8'(i) ^ 8'ha5;
    endcase
  endfunction
  // Answers discovery with one pulse, then each strobe after a delay.
  always @(posedge sys_clk) begin
    if (enclosure_link_request_n) begin
      enclosure_acknowledge_n <= 1'b1;
      cnt <= 0;
      nrd <= 0;
      ncmd <= 0;
      disc_pend <= 1'b1;
    end else if (disc_pend) begin
      cnt <= cnt + 1;
      if (cnt == int'(dly) && !mute_disc) enclosure_acknowledge_n <= 1'b0;
      if (cnt == int'(dly) + 8) begin
        enclosure_acknowledge_n <= 1'b1;
        disc_pend <= 1'b0;
        cnt <= 0;
      end
    end else if (enclosure_acknowledge_n && strobe && !stall) begin
      if (!device_read_strobe_n) link_data_in <= pbyte(nrd);
      cnt <= (cnt == int'(dly)) ? 0 : cnt + 1;
      if (cnt == int'(dly)) begin
        enclosure_acknowledge_n <= 1'b0;
        if (!device_write_strobe_n) cmd_seen[8*ncmd +: 8] <= link_data_out;
        if (!device_write_strobe_n) ncmd <= ncmd + 1;
        else nrd <= nrd + 1;
      end
    end else if (!enclosure_acknowledge_n && !strobe) begin
      // Released data shows the inverse, so a stale byte is never read.
      enclosure_acknowledge_n <= 1'b1;
      link_data_in <= ~link_data_in;
    end
  end
endmodule // ers_encl_model

`default_nettype wire

/* testbench/enclosure_status_read_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module enclosure_status_read_sequencer_bench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic host_req = 1'b0;
  logic [7:0] host_page_code = 8'h00;
  logic [15:0] host_alloc_len = 16'h0000;
  logic host_busy, host_done, host_check, host_data_valid;
  logic [7:0] host_asc, host_ascq, host_data, link_data_in, link_data_out;
  logic disc_start, link_data_oe, enclosure_acknowledge_n;
  logic enclosure_link_request_n, device_write_strobe_n, device_read_strobe_n;
  logic disc_done = 1'b0;
  logic disc_compliant = 1'b1;
  logic disc_legacy_link_ok = 1'b0;
  logic legacy_link_bit_high = 1'b0;
  logic legacy_link_bit_low = 1'b0;
  logic mute_disc = 1'b0;
  logic [7:0] stall_wr = 8'hff;
  logic [7:0] stall_rd = 8'hff;
  logic [15:0] page_len = 16'h0006;
  logic [31:0] cmd_seen;
  logic [2:0] disc_wait = 3'h0;
  logic [7:0] got [$];
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  ers_sequencer #(.DISC_TIMEOUT_CYC(200), .FIRST_RD_TIMEOUT_CYC(50), .BYTE_TIMEOUT_CYC(20))
  i_ers_sequencer (
    .sys_clk, .srst, .host_req, .host_page_code, .host_alloc_len, .host_busy, .host_done,
    .host_check, .host_asc, .host_ascq, .host_data_valid, .host_data, .disc_start, .disc_done,
    .disc_compliant, .disc_legacy_link_ok, .enclosure_link_request_n, .device_write_strobe_n,
    .device_read_strobe_n, .enclosure_acknowledge_n, .legacy_link_bit_high,
    .legacy_link_bit_low, .link_data_in, .link_data_out, .link_data_oe);

  ers_encl_model i_ers_encl_model (
    .sys_clk, .enclosure_link_request_n, .device_write_strobe_n, .device_read_strobe_n,
    .link_data_out, .enclosure_acknowledge_n, .link_data_in, .dly(4'h3), .mute_disc,
    .stall_wr, .stall_rd, .page_len, .cmd_seen);

  always #10 sys_clk = ~sys_clk;

  // Discovery logic stand-in: result four cycles after each start.
  always @(posedge sys_clk) begin
    disc_done <= (disc_wait == 3'h1);
    disc_wait <= (disc_start === 1'b1) ? 3'h3 : (disc_wait != 3'h0 ? disc_wait - 3'h1 : 3'h0);
  end

  // Collects every byte handed to the host.
  always @(posedge sys_clk) if (host_data_valid === 1'b1) got.push_back(host_data);

  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %b want %b", $time, m, g, e);
    end
  endtask

  // Expected enclosure page byte.
  function automatic logic [7:0] pb(input int i, input logic [7:0] pc, input logic [15:0] pl);
    if (i == 0) return pc;
    if (i == 1) return 8'h5a;
    if (i == 2) return pl[15:8];
    if (i == 3) return pl[7:0];
    return 8'(i) ^ 8'ha5;
  endfunction

  // One host request, waited on until done.
  task automatic run(input logic [7:0] pc, input logic [15:0] alloc);
    int k;
    repeat (8) @(posedge sys_clk);
    got.delete();
    host_req <= 1'b1;
    host_page_code <= pc;
    host_alloc_len <= alloc;
    @(posedge sys_clk);
    host_req <= 1'b0;
    for (k = 0; k < 3000 && host_done !== 1'b1; k++) @(posedge sys_clk);
    cmp1(host_done, 1'b1, "no done");
  endtask

  task automatic chk_status(input logic chk, input logic [7:0] ascq);
    cmp1(host_check, chk, "status");
    cmp8(host_asc, chk ? 8'h35 : 8'h00, "asc");
    cmp8(host_ascq, ascq, "ascq");
  endtask

  task automatic t_pass(input logic [7:0] pc, input logic [15:0] pl, input logic [15:0] al);
    int n;
    int i;
    n = (int'(pl) + 4 < int'(al)) ? int'(pl) + 4 : int'(al);
    page_len <= pl;
    disc_compliant <= 1'b1;
    disc_legacy_link_ok <= 1'b0;
    run(pc, al);
    chk_status(1'b0, 8'h00);
    cmp8(8'(got.size()), 8'(n), "count");
    for (i = 0; i < n && i < got.size(); i++) cmp8(got[i], pb(i, pc, pl), "byte");
    cmp8(cmd_seen[7:0], pc, "cmd page");
    cmp8(cmd_seen[15:8], 8'h00, "cmd send");
    cmp8(cmd_seen[31:24] | cmd_seen[23:16], 8'h00, "cmd length");
  endtask

  task automatic t_legacy(input logic [1:0] bits, input logic [15:0] al);
    int i;
    logic [31:0] sp;
    sp = {8'h08, 1'b1, 5'h00, bits, 16'h0000};
    disc_compliant <= 1'b0;
    disc_legacy_link_ok <= 1'b1;
    legacy_link_bit_high <= bits[1];
    legacy_link_bit_low <= bits[0];
    run(8'h03, al);
    chk_status(1'b0, 8'h00);
    cmp8(8'(got.size()), al < 16'h0004 ? al[7:0] : 8'h04, "short count");
    for (i = 0; i < got.size() && i < 4; i++) cmp8(got[i], sp[31-8*i -: 8], "short byte");
  endtask

  task automatic t_fail(input logic [1:0] kind, input logic mute, input logic [7:0] swr,
    input logic [7:0] srd, input logic [7:0] ascq);
    disc_compliant <= kind[0];
    disc_legacy_link_ok <= kind[1];
    mute_disc <= mute;
    stall_wr <= swr;
    stall_rd <= srd;
    page_len <= 16'h0010;
    run(8'h05, 16'h0040);
    chk_status(1'b1, ascq);
    mute_disc <= 1'b0;
    stall_wr <= 8'hff;
    stall_rd <= 8'hff;
  endtask

  task automatic t_ignored(input logic [7:0] pc);
    @(posedge sys_clk);
    host_req <= 1'b1;
    host_page_code <= pc;
    @(posedge sys_clk);
    host_req <= 1'b0;
    repeat (6) begin
      @(posedge sys_clk);
      cmp1(host_busy | disc_start, 1'b0, "ignored code");
    end
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_ignored(8'h00);
    t_ignored(8'h10);
    t_pass(8'h01, 16'h0006, 16'h0064);
    t_pass(8'h0f, 16'h0014, 16'h0007);
    t_pass(8'h02, 16'h0000, 16'h0004);
    t_legacy(2'b10, 16'h0010);
    t_legacy(2'b01, 16'h0002);
    t_fail(2'b00, 1'b0, 8'hff, 8'hff, 8'h01);
    t_fail(2'b01, 1'b1, 8'hff, 8'hff, 8'h02);
    t_fail(2'b01, 1'b0, 8'h02, 8'hff, 8'h03);
    t_fail(2'b01, 1'b0, 8'hff, 8'h00, 8'h03);
    t_fail(2'b01, 1'b0, 8'hff, 8'h05, 8'h04);
    t_pass(8'h07, 16'h0003, 16'h0020);
    tally_and_finish();
  end
endmodule // enclosure_status_read_sequencer_bench

`default_nettype wire
